// ---- design/wwd_top.sv ----
// windowed watchdog: apb registers, 12-bit down counter, fault outputs
// assumes presetn is the processor reset, also driven on watchdog reset
// assumes slow_clk, proc_debug and sys_idle are plain asynchronous levels
//
// The APB interface to the registers was decided locally.
`default_nettype none

// Operation
// - twelve-bit down counter reloads from the counter load value field.
// - counter decrements once per slow clock divided by 128.
// - after processor reset load value is 0xFFF, counter runs, reset on.
// - mode register resets to 0x3FFF_2FFF; window open over whole range.
// - mode register takes one write after reset, later writes ignored.
// - accepted mode write reloads counter and restarts with new settings.
// - valid restart reloads counter and restarts the divide-by-128.
// - control write needs key 0xA5 in bits 31:24, bit 0 restarts.
// - underflow sets sticky flag; with reset enable asserts fault.
// - restart above delta sets error and fault, even when disabled.
// - delta not below load value lets restart anywhere, never errors.
// - interrupt enable gates underflow or error onto the interrupt.
// - with reset enable, fault requests processor reset or all resets by select bit.
// - watchdog reset resets processor and watchdog, clears both flags.
// - status read or reset clears flags, interrupt and fault.
// - counter stops in debug or idle when the matching halt bit is set.
// - disable bit stops the counter; clearing it enables the timer.
// - mode fields: load 11:0, enables 12-13, select 14, disable 15, delta 27:16, halts 28-29.
// - status holds underflow in bit 0 and error in bit 1, sticky.
module wwd_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire wwd_pkg::wwd_apb_req_t apb_req,
  output wwd_pkg::wwd_apb_rsp_t      apb_rsp,
  input  wire logic                  slow_clk,
  input  wire logic                  proc_debug,
  input  wire logic                  sys_idle,
  output logic                       wdt_fault,
  output logic                       wdt_irq,
  output logic                       proc_reset_req,
  output logic                       all_reset_req
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  wwd_pkg::wwd_state_t               st_ff;
  wwd_pkg::wwd_state_t               nxt_st;
  logic [wwd_pkg::SYNC_W-1:0]        async_in;
  logic [wwd_pkg::SYNC_W-1:0]        sync_out;
  logic                              slow_s;
  logic                              debug_s;
  logic                              idle_s;
  logic                              tick;
  logic                              pre_restart;
  logic                              setup;
  logic                              access;
  logic                              sel_cmd;
  logic                              sel_mode;
  logic                              sel_flags;
  logic                              mapped;
  logic                              wr_cmd;
  logic                              wr_mode;
  logic                              rd_flags;
  logic                              key_ok;
  logic                              restart_req;
  logic                              in_window;
  logic                              window_off;
  logic                              restart_ok;
  logic                              restart_bad;
  logic                              mode_accept;
  logic                              halted;
  logic                              running;
  logic                              unf_evt;
  logic                              err_evt;
  logic                              clr_unf;
  logic                              clr_err;
  logic [wwd_pkg::CNT_W-1:0]         load_val;
  logic [wwd_pkg::CNT_W-1:0]         delta_val;
  logic [wwd_pkg::CNT_W-1:0]         new_load;
  logic [31:0]                       rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and prescaler
  assign async_in = {sys_idle, proc_debug, slow_clk};

  wwd_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (async_in),
    .dout    (sync_out)
  );

  assign slow_s  = sync_out[0];
  assign debug_s = sync_out[1];
  assign idle_s  = sync_out[2];

  wwd_prescale u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .slow_s  (slow_s),
    .restart (pre_restart),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup     = apb_req.psel & ~apb_req.penable;
  assign access    = apb_req.psel & apb_req.penable;
  assign sel_cmd   = apb_req.paddr == wwd_pkg::OFS_RESTART_CMD;
  assign sel_mode  = apb_req.paddr == wwd_pkg::OFS_MODE_ONCE;
  assign sel_flags = apb_req.paddr == wwd_pkg::OFS_FAULT_FLAGS;
  assign mapped    = sel_cmd | sel_mode | sel_flags;

  assign wr_cmd    = access & apb_req.pwrite & sel_cmd;
  assign wr_mode   = access & apb_req.pwrite & sel_mode;
  assign rd_flags  = access & ~apb_req.pwrite & sel_flags;

  ////////////////////////////////////////////////////////////////////////
  // mode fields
  assign load_val  = st_ff.mode[wwd_pkg::LOAD_MSB:wwd_pkg::LOAD_LSB];
  assign delta_val =
    st_ff.mode[wwd_pkg::DELTA_MSB:wwd_pkg::DELTA_LSB];
  assign new_load  = apb_req.pwdata[wwd_pkg::LOAD_MSB:wwd_pkg::LOAD_LSB];

  ////////////////////////////////////////////////////////////////////////
  // restart command and window check
  assign key_ok =
    apb_req.pwdata[wwd_pkg::KEY_MSB:wwd_pkg::KEY_LSB]
      == wwd_pkg::KEY_VALUE;
  assign restart_req =
    wr_cmd & key_ok & apb_req.pwdata[wwd_pkg::RESTART_BIT];
  assign window_off  = delta_val >= load_val;
  assign in_window   = st_ff.count <= delta_val;
  assign restart_ok  = restart_req & (in_window | window_off);
  assign restart_bad = restart_req & ~in_window & ~window_off;

  ////////////////////////////////////////////////////////////////////////
  // one-time mode write
  assign mode_accept = wr_mode & ~st_ff.written;
  assign pre_restart = restart_ok | mode_accept;

  ////////////////////////////////////////////////////////////////////////
  // run control
  assign halted =
    (st_ff.mode[wwd_pkg::DBGHLT_BIT] & debug_s) |
    (st_ff.mode[wwd_pkg::IDLEHLT_BIT] & idle_s);
  assign running = ~st_ff.mode[wwd_pkg::DIS_BIT] & ~halted;
  assign unf_evt =
    running & tick & ~pre_restart & (st_ff.count == '0);
  assign err_evt = restart_bad;

  ////////////////////////////////////////////////////////////////////////
  // status read clears only what the read reported
  assign clr_unf = rd_flags & st_ff.rdata[wwd_pkg::UNF_BIT];
  assign clr_err = rd_flags & st_ff.rdata[wwd_pkg::ERR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // read data, sampled in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (apb_req.paddr)
      wwd_pkg::OFS_MODE_ONCE: begin
        rd_mux = st_ff.mode;
      end
      wwd_pkg::OFS_FAULT_FLAGS: begin
        rd_mux[wwd_pkg::UNF_BIT] = st_ff.unf;
        rd_mux[wwd_pkg::ERR_BIT] = st_ff.err;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st = st_ff;

    if (setup && !apb_req.pwrite) begin
      nxt_st.rdata = rd_mux;
    end

    if (mode_accept) begin
      nxt_st.mode    = apb_req.pwdata & wwd_pkg::MODE_WMASK;
      nxt_st.written = 1'b1;
      nxt_st.count   = new_load;
    end else if (restart_ok) begin
      nxt_st.count = load_val;
    end else if (running && tick) begin
      if (st_ff.count == '0) begin
        nxt_st.count = load_val;
      end else begin
        nxt_st.count = st_ff.count - 12'h001;
      end
    end

    nxt_st.unf = (st_ff.unf & ~clr_unf) | unf_evt;
    nxt_st.err = (st_ff.err & ~clr_err) | err_evt;

    if (rd_flags) begin
      nxt_st.fault = 1'b0;
    end
    if ((unf_evt && st_ff.mode[wwd_pkg::RSTEN_BIT]) || err_evt) begin
      nxt_st.fault = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset also covers a watchdog-triggered reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.mode    <= wwd_pkg::MODE_RESET;
      st_ff.written <= 1'b0;
      st_ff.count   <= wwd_pkg::MODE_RESET[11:0];
      st_ff.unf     <= 1'b0;
      st_ff.err     <= 1'b0;
      st_ff.fault   <= 1'b0;
      st_ff.rdata   <= wwd_pkg::FLAGS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign apb_rsp.prdata  = st_ff.rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access & ~mapped;

  assign wdt_fault = st_ff.fault;
  assign wdt_irq   =
    st_ff.mode[wwd_pkg::FIEN_BIT] & (st_ff.unf | st_ff.err);
  assign proc_reset_req =
    st_ff.fault & st_ff.mode[wwd_pkg::RSTEN_BIT]
    & st_ff.mode[wwd_pkg::PROCSEL_BIT];
  assign all_reset_req =
    st_ff.fault & st_ff.mode[wwd_pkg::RSTEN_BIT]
    & ~st_ff.mode[wwd_pkg::PROCSEL_BIT];

endmodule : wwd_top

`default_nettype wire

// ---- pkg/wwd_pkg.sv ----
// package of the windowed watchdog: map, fields, reset values, carriers
// assumes a single pclk domain and a 32-bit apb slave port
`default_nettype none

package wwd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0]  OFS_RESTART_CMD = 8'h00;
  localparam logic [7:0]  OFS_MODE_ONCE   = 8'h04;
  localparam logic [7:0]  OFS_FAULT_FLAGS = 8'h08;

  ////////////////////////////////////////////////////////////////////////
  // mode register fields
  localparam logic [31:0] MODE_RESET   = 32'h3FFF_2FFF;
  localparam logic [31:0] MODE_WMASK   = 32'h3FFF_FFFF;
  localparam int unsigned LOAD_LSB     = 0;
  localparam int unsigned LOAD_MSB     = 11;
  localparam int unsigned FIEN_BIT     = 12;
  localparam int unsigned RSTEN_BIT    = 13;
  localparam int unsigned PROCSEL_BIT  = 14;
  localparam int unsigned DIS_BIT      = 15;
  localparam int unsigned DELTA_LSB    = 16;
  localparam int unsigned DELTA_MSB    = 27;
  localparam int unsigned DBGHLT_BIT   = 28;
  localparam int unsigned IDLEHLT_BIT  = 29;

  ////////////////////////////////////////////////////////////////////////
  // restart command and status fields
  localparam int unsigned KEY_LSB      = 24;
  localparam int unsigned KEY_MSB      = 31;
  localparam logic [7:0]  KEY_VALUE    = 8'hA5;
  localparam int unsigned RESTART_BIT  = 0;
  localparam int unsigned UNF_BIT      = 0;
  localparam int unsigned ERR_BIT      = 1;
  localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // counter and prescaler
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned PRE_DIV      = 128;
  localparam int unsigned PRE_W        = 7;
  localparam logic [6:0]  PRE_LAST     = 7'(PRE_DIV - 1);
  localparam int unsigned SYNC_W       = 3;

  ////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } wwd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wwd_apb_rsp_t;

  typedef struct packed {
    logic [31:0]      mode;
    logic             written;
    logic [CNT_W-1:0] count;
    logic             unf;
    logic             err;
    logic             fault;
    logic [31:0]      rdata;
  } wwd_state_t;

  typedef struct packed {
    logic [PRE_W-1:0] div;
    logic             slow_prev;
    logic             tick;
  } wwd_pre_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } wwd_sync_state_t;

endpackage : wwd_pkg

`default_nettype wire

// ---- design/wwd_sync.sv ----
// two-flop synchroniser for slow clock, debug and idle levels
// assumes inputs may change at any time relative to pclk
`default_nettype none

module wwd_sync (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [wwd_pkg::SYNC_W-1:0] din,
  output logic      [wwd_pkg::SYNC_W-1:0] dout
);

  wwd_pkg::wwd_sync_state_t st_ff;
  wwd_pkg::wwd_sync_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = din;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.sync;

endmodule : wwd_sync

`default_nettype wire

// ---- design/wwd_prescale.sv ----
// divide-by-128 prescaler of synchronised slow clock edges
// assumes slow_s is already synchronised to pclk
`default_nettype none

module wwd_prescale (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow_s,
  input  wire logic restart,
  output logic      tick
);

  wwd_pkg::wwd_pre_state_t st_ff;
  wwd_pkg::wwd_pre_state_t nxt_st;
  logic                    slow_rise;

  ////////////////////////////////////////////////////////////////////////
  // count slow edges, pulse tick on the 128th
  always_comb begin
    nxt_st           = st_ff;
    slow_rise        = slow_s & ~st_ff.slow_prev;
    nxt_st.slow_prev = slow_s;
    nxt_st.tick      = 1'b0;
    if (restart) begin
      nxt_st.div = '0;
    end else if (slow_rise) begin
      if (st_ff.div == wwd_pkg::PRE_LAST) begin
        nxt_st.div  = '0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.div = st_ff.div + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : wwd_prescale

`default_nettype wire

// ---- dv/wwd_checker.sv ----
// checker: port-level relations of the windowed watchdog top
// assumes it is bound to wwd_top and sees only its ports
`default_nettype none

module wwd_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire wwd_pkg::wwd_apb_req_t apb_req,
  input wire wwd_pkg::wwd_apb_rsp_t apb_rsp,
  input wire logic                  wdt_fault,
  input wire logic                  wdt_irq,
  input wire logic                  proc_reset_req,
  input wire logic                  all_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic       acc = apb_req.psel && apb_req.penable;
  wire logic       rd  = acc && !apb_req.pwrite;
  wire logic       stp = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  wire logic [7:0] a   = apb_req.paddr;

  ////////////////////////////////////////////////////////////////////////
  // sequences
  sequence s_rd(logic [7:0] x);
    rd && a == x;
  endsequence
  sequence s_quiet;
    !wdt_fault && !wdt_irq;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // properties
  property p_excl; !(proc_reset_req && all_reset_req); endproperty
  property p_req; (proc_reset_req || all_reset_req) |-> wdt_fault; endproperty
  property p_boot; $rose(presetn) |-> s_quiet; endproperty
  property p_clr; s_rd(8'h08) |=> s_quiet; endproperty
  property p_irq_hold; wdt_irq && !rd |=> wdt_irq; endproperty
  property p_flt_hold; wdt_fault && !rd |=> wdt_fault; endproperty
  property p_hold; !stp |=> $stable(apb_rsp.prdata); endproperty
  property p_cr_zero; s_rd(8'h00) |-> apb_rsp.prdata == 32'h0; endproperty
  property p_mode_hi; s_rd(8'h04) |-> apb_rsp.prdata[31:30] == 2'h0;
  endproperty
  property p_flag_hi; s_rd(8'h08) |-> apb_rsp.prdata[31:2] == 30'h0;
  endproperty
  property p_slverr;
    acc |-> apb_rsp.pslverr == !(a == 8'h00 || a == 8'h04 || a == 8'h08);
  endproperty

  a_excl: assert property (p_excl)
    else $error("both reset requests high");
  a_req: assert property (p_req)
    else $error("reset request without fault");
  a_boot: assert property (p_boot)
    else $error("fault or irq after reset");
  a_clr: assert property (p_clr)
    else $error("status read did not clear");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without read");
  a_flt_hold: assert property (p_flt_hold)
    else $error("fault dropped without read");
  a_hold: assert property (p_hold)
    else $error("read data changed outside setup");
  a_cr_zero: assert property (p_cr_zero)
    else $error("command register read not zero");
  a_mode_hi: assert property (p_mode_hi)
    else $error("mode top bits not zero");
  a_flag_hi: assert property (p_flag_hi)
    else $error("flag upper bits not zero");
  a_slverr: assert property (p_slverr)
    else $error("slave error mismatch");
endmodule : wwd_checker

bind wwd_top wwd_checker wwd_checker_i (.pclk, .presetn, .apb_req, .apb_rsp,
  .wdt_fault, .wdt_irq, .proc_reset_req, .all_reset_req);

`default_nettype wire

// ---- dv/wwd_rstc_model.sv ----
// model of reset controller and slow clock source
// assumes pclk runs; slow clock period is 8 pclk, free running
`default_nettype none

module wwd_rstc_model (
  input  wire logic pclk,
  input  wire logic por_n,
  input  wire logic proc_reset_req,
  input  wire logic all_reset_req,
  output logic      presetn,
  output var logic  slow_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_ff;
  logic [1:0] sdiv_ff;

  // either request resets processor and watchdog for 4 cycles
  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      hold_ff <= 3'h0;
    end else if (proc_reset_req || all_reset_req) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
  assign presetn = por_n && (hold_ff == 3'h0);

  always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      sdiv_ff  <= 2'h0;
      slow_clk <= 1'b0;
    end else begin
      sdiv_ff <= sdiv_ff + 2'h1;
      if (sdiv_ff == 2'h3) slow_clk <= ~slow_clk;
    end
  end
endmodule : wwd_rstc_model

`default_nettype wire

// ---- dv/wwd_top_tb.sv ----
// testbench of the windowed watchdog top over apb
// assumes reset controller model in wwd_rstc_model
`default_nettype none

module wwd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk, por_n, presetn, slow_clk, proc_debug;
  logic                  sys_idle, wdt_fault, wdt_irq;
  logic                  proc_reset_req, all_reset_req;
  wwd_pkg::wwd_apb_req_t req;
  wwd_pkg::wwd_apb_rsp_t rsp;
  int                    mismatches, checks, cyc, n;
  logic [31:0]           q;
  logic                  e;

  wwd_top wwd_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .slow_clk(slow_clk), .proc_debug(proc_debug),
    .sys_idle(sys_idle), .wdt_fault(wdt_fault), .wdt_irq(wdt_irq),
    .proc_reset_req(proc_reset_req), .all_reset_req(all_reset_req));
  wwd_rstc_model wwd_rstc_model_i (.pclk(pclk), .por_n(por_n),
    .proc_reset_req(proc_reset_req), .all_reset_req(all_reset_req),
    .presetn(presetn), .slow_clk(slow_clk));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : xfer

  task automatic por;
    @(posedge pclk);
    por_n <= 1'b0;
    repeat (10) @(posedge pclk);
    por_n <= 1'b1;
    @(posedge pclk);
  endtask : por

  task automatic wt(input int lim, input bit ar);
    n = 0;
    #1;
    while ((ar ? all_reset_req : wdt_irq) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wt

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    xfer(1'b0, 8'h04, 32'h0);
    chk("mode", wwd_pkg::MODE_RESET, q);
    xfer(1'b0, 8'h08, 32'h0);
    chk("flags", 32'h0, q);
    xfer(1'b0, 8'h00, 32'h0);
    chk("cmd_rd", 32'h0, q);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    $display("test regs done");
  endtask : t_regs

  task automatic t_unf;
    xfer(1'b1, 8'h04, 32'h0002_1002);
    wt(4000, 1'b0);
    chk("unf_time", 32'h1, 32'(n >= 3050 && n <= 3090));
    chk("reqs", 32'h0, 32'(proc_reset_req | all_reset_req));
    xfer(1'b1, 8'h04, 32'h0000_0FFF);
    xfer(1'b0, 8'h04, 32'h0);
    chk("mode_once", 32'h0002_1002, q);
    xfer(1'b0, 8'h08, 32'h0);
    chk("flags", 32'h1, q);
    @(posedge pclk);
    chk("irq", 32'h0, 32'(wdt_irq));
    xfer(1'b0, 8'h08, 32'h0);
    chk("flags_clr", 32'h0, q);
    $display("test underflow done");
  endtask : t_unf

  task automatic t_win;
    xfer(1'b1, 8'h04, 32'h0010_2100);
    xfer(1'b1, 8'h00, 32'h5A00_0001);
    repeat (4) @(posedge pclk);
    chk("bad_key", 32'h0, 32'(wdt_fault));
    xfer(1'b1, 8'h00, 32'hA500_0001);
    wt(20, 1'b1);
    chk("all_req", 32'h1, 32'(all_reset_req));
    chk("proc_req", 32'h0, 32'(proc_reset_req));
    repeat (8) @(posedge pclk);
    xfer(1'b0, 8'h04, 32'h0);
    chk("mode_rst", wwd_pkg::MODE_RESET, q);
    xfer(1'b0, 8'h08, 32'h0);
    chk("flags_rst", 32'h0, q);
    xfer(1'b1, 8'h00, 32'hA500_0001);
    repeat (4) @(posedge pclk);
    chk("open_win", 32'h0, 32'(wdt_fault));
    xfer(1'b1, 8'h04, 32'h0000_9001);
    wt(3000, 1'b0);
    chk("disabled", 32'h0, 32'(wdt_irq));
    $display("test window done");
  endtask : t_win

  task automatic t_halt;
    proc_debug <= 1'b1;
    xfer(1'b1, 8'h04, 32'h3000_1001);
    wt(3000, 1'b0);
    chk("halted", 32'h0, 32'(wdt_irq));
    @(posedge pclk);
    proc_debug <= 1'b0;
    sys_idle   <= 1'b1;
    wt(3000, 1'b0);
    chk("idle_halted", 32'h0, 32'(wdt_irq));
    @(posedge pclk);
    sys_idle <= 1'b0;
    wt(3000, 1'b0);
    chk("resumed", 32'h1, 32'(wdt_irq));
    $display("test halt done");
  endtask : t_halt

  task automatic t_proc;
    xfer(1'b1, 8'h04, 32'h0010_E100);
    xfer(1'b1, 8'h00, 32'hA500_0001);
    #1;
    chk("proc_only", 32'h1, 32'(proc_reset_req));
    chk("no_all", 32'h0, 32'(all_reset_req));
    repeat (8) @(posedge pclk);
    xfer(1'b0, 8'h08, 32'h0);
    chk("flags_proc", 32'h0, q);
    $display("test processor reset done");
  endtask : t_proc

  initial begin
    mismatches = 0;
    checks     = 0;
    cyc        = 0;
    req        = '0;
    proc_debug = 1'b0;
    sys_idle   = 1'b0;
    por_n      = 1'b0;
    por();
    t_regs();
    t_unf();
    por();
    t_win();
    por();
    t_halt();
    por();
    t_proc();
    complete_run();
  end
endmodule : wwd_top_tb

`default_nettype wire
